// >>> rtl/wds_device.sv
// Watchdog supervisor: serial slave, mode tracking, timer and failure handling
//
// Behaviour
// [R1] Time-out or window type, time-out default
// [R2] Config changes only in normal; stop holds it
// [R3] Long window after init release; normal entry
// [R4] New timing restarts the timer at once
// [R5] Trigger acted on when select_n rises
// [R6] Long open window lasts 200 ms
// [R7] Seven periods, 10 to 1000 ms
// [R8] Failure: reset low, restart/fail-safe, count update
// [R9] Reset release starts long window, normal mode
// [R10] Development mode: watchdog off, no reset
// [R11] Failure count increments, saturates per config
// [R12] Failure count cleared on success or off
// [R13] Time-out: any trigger restarts full period
// [R14] Time-out expiry gives watchdog reset
// [R15] Window: 60% closed, period mid open window
// [R16] Window: early trigger or expiry resets
// [R17] Even parity over config word data byte
// [R18] Bad parity: discard, set serial error
// [R19] Reserved bit 3 counts in parity
// [R20] Two arming bits set to disable in stop
// [R21] Sequence violation clears second arming bit
// [R22] Stop trigger or normal re-enables, clears arms
// [R23] Restart with first arm set clears it
// [R24] One tick counter times all windows
`timescale 1ns/100ps
`default_nettype none
module wds_device #(
   parameter int TICK_CYC_P = wds_pkg::TICK_CYC,
   parameter int RST_HOLD_P = wds_pkg::RST_HOLD_CYC
) (
   input wire logic clk,
   input wire logic rst_n,
   wds_link_if.dev link,
   input wire logic dev_mode,
   input wire logic [1:0] fail_cfg,
   output logic reset_out_n,
   output logic [2:0] sbc_mode,
   output logic [1:0] failure_count,
   output logic serial_error,
   output logic wd_running
);
   typedef struct packed {
      logic sel_s1, sel_s2, sel_prev;
      logic sclk_s1, sclk_s2, sclk_prev;
      logic mosi_s1, mosi_s2;
      logic dev_s1, dev_s2;
      logic [1:0] cfg_s1, cfg_s2;
      logic [15:0] shift_in;
      logic [15:0] shift_out;
      logic [4:0] bit_cnt;
      logic miso, miso_oe_n;
      logic [7:0] rdata;
      logic [7:0] cfg;
      logic arm1;
      wds_pkg::wds_mode_e mode;
      logic [1:0] fail_cnt;
      logic ser_err;
      logic long_win;
      logic stop_off;
      logic [19:0] pre;
      logic [10:0] ms;
      logic [15:0] rst_cnt;
      logic reset_out_n;
      logic wd_on;
   } wds_dev_s;

   wds_dev_s state_reg, state_next;

   function automatic logic [10:0] pct_of(input logic [10:0] p, input int pct);
      return 11'((32'(p) * pct) / 100);
   endfunction : pct_of

   logic sclk_rise, sclk_fall, sel_fall, sel_rise;
   logic [7:0] d;
   logic [6:0] addr;
   logic trig, timing_chg, fail, restart_tmr, wd_on;
   logic [10:0] per, limit;
   logic [1:0] fail_max;
   logic [7:0] status;

   always_comb begin
      state_next = state_reg;
      trig = 1'b0;
      timing_chg = 1'b0;
      fail = 1'b0;
      restart_tmr = 1'b0;
      d = state_reg.shift_in[15:8];
      addr = state_reg.shift_in[6:0];
      per = wds_pkg::wds_period_ms(state_reg.cfg[wds_pkg::CFG_PER_LSB +: 3]); // R7
      fail_max = (state_reg.cfg_s2 == 2'h1) ? 2'h1 : 2'h2;
      status = {state_reg.mode, state_reg.fail_cnt, state_reg.ser_err, state_reg.wd_on,
                state_reg.long_win};
      // Pin synchronisers
      state_next.sel_s1 = link.select_n;
      state_next.sel_s2 = state_reg.sel_s1;
      state_next.sclk_s1 = link.sclk;
      state_next.sclk_s2 = state_reg.sclk_s1;
      state_next.mosi_s1 = link.mosi;
      state_next.mosi_s2 = state_reg.mosi_s1;
      state_next.dev_s1 = dev_mode;
      state_next.dev_s2 = state_reg.dev_s1;
      state_next.cfg_s1 = fail_cfg;
      state_next.cfg_s2 = state_reg.cfg_s1;
      state_next.sel_prev = state_reg.sel_s2;
      state_next.sclk_prev = state_reg.sclk_s2;
      sclk_rise = state_reg.sclk_s2 & ~state_reg.sclk_prev;
      sclk_fall = ~state_reg.sclk_s2 & state_reg.sclk_prev;
      sel_fall = ~state_reg.sel_s2 & state_reg.sel_prev;
      sel_rise = state_reg.sel_s2 & ~state_reg.sel_prev;

      // Serial shifter, mode 0, MSB first
      if (sel_fall) begin
         state_next.bit_cnt = 5'd0;
         state_next.shift_out = {state_reg.rdata, status};
         state_next.miso = state_reg.rdata[7];
         state_next.miso_oe_n = 1'b0;
      end else if (!state_reg.sel_s2) begin
         if (sclk_rise) begin
            state_next.shift_in = {state_reg.shift_in[14:0], state_reg.mosi_s2};
            if (state_reg.bit_cnt != 5'd31) begin
               state_next.bit_cnt = state_reg.bit_cnt + 5'd1;
            end
         end
         if (sclk_fall) begin
            state_next.shift_out = {state_reg.shift_out[14:0], 1'b0};
            state_next.miso = state_reg.shift_out[14];
         end
      end

      // Frame is executed only at the end of select
      if (sel_rise) begin // R5
         state_next.miso_oe_n = 1'b1;
         if (state_reg.bit_cnt != 5'(wds_pkg::FRAME_BITS)) begin
            state_next.ser_err = 1'b1;
         end else if (!state_reg.shift_in[wds_pkg::FRM_WR_BIT]) begin
            case (addr)
               wds_pkg::ADDR_MODE: state_next.rdata = {5'h00, state_reg.mode};
               wds_pkg::ADDR_WAKE: state_next.rdata = {7'h00, state_reg.arm1};
               // Reserved bit always reads as zero
               wds_pkg::ADDR_WDCFG: state_next.rdata = state_reg.cfg;
               wds_pkg::ADDR_STAT: begin
                  state_next.rdata = status;
                  state_next.ser_err = 1'b0;
               end
               default: state_next.rdata = 8'h00;
            endcase
         end else begin
            case (addr)
               wds_pkg::ADDR_WDCFG: begin
                  if (wds_pkg::wds_parity(d)) begin // R17 R19
                     state_next.ser_err = 1'b1; // R18
                  end else begin
                     trig = 1'b1; // R5
                     if (state_reg.mode == wds_pkg::WDS_NORMAL) begin // R2
                        state_next.cfg = d;
                        state_next.cfg[wds_pkg::CFG_RSV_BIT] = 1'b0;
                        // Second arm only sticks after the first one
                        state_next.cfg[wds_pkg::CFG_ARM2_BIT] =
                           d[wds_pkg::CFG_ARM2_BIT] & state_reg.arm1; // R20 R21
                        timing_chg = (d[5:0] & 6'h27) != (state_reg.cfg[5:0] & 6'h27); // R4
                     end
                  end
               end
               wds_pkg::ADDR_WAKE: begin
                  if (state_reg.mode == wds_pkg::WDS_NORMAL) begin
                     // Starting over with the arm already set drops it
                     state_next.arm1 = d[wds_pkg::WAKE_ARM1_BIT] & ~state_reg.arm1; // R20 R23
                  end
               end
               wds_pkg::ADDR_MODE: begin
                  case (d[1:0])
                     wds_pkg::CMD_NORMAL: begin
                        if (state_reg.mode == wds_pkg::WDS_INIT) begin
                           state_next.mode = wds_pkg::WDS_NORMAL;
                        end else if (state_reg.mode == wds_pkg::WDS_STOP ||
                                     state_reg.mode == wds_pkg::WDS_SLEEP) begin
                           state_next.mode = wds_pkg::WDS_NORMAL;
                           state_next.long_win = 1'b1; // R3 R22
                           state_next.stop_off = 1'b0;
                           state_next.arm1 = 1'b0;
                           state_next.cfg[wds_pkg::CFG_ARM2_BIT] = 1'b0;
                           restart_tmr = 1'b1;
                        end
                     end
                     wds_pkg::CMD_STOP: begin
                        if (state_reg.mode == wds_pkg::WDS_NORMAL) begin
                           state_next.mode = wds_pkg::WDS_STOP;
                           state_next.stop_off = state_reg.arm1 &
                              state_reg.cfg[wds_pkg::CFG_ARM2_BIT]; // R20
                        end
                     end
                     wds_pkg::CMD_SLEEP: begin
                        if (state_reg.mode == wds_pkg::WDS_NORMAL) begin
                           state_next.mode = wds_pkg::WDS_SLEEP; // R3
                        end
                     end
                     default: ;
                  endcase
               end
               default: ;
            endcase
         end
      end

      wd_on = !state_reg.dev_s2 && state_reg.reset_out_n && // R10
              (state_reg.mode == wds_pkg::WDS_INIT || state_reg.mode == wds_pkg::WDS_NORMAL ||
               (state_reg.mode == wds_pkg::WDS_STOP && !state_reg.stop_off));
      state_next.wd_on = wd_on;
      limit = state_reg.long_win ? 11'(wds_pkg::LONG_WIN_MS) : // R6
              state_reg.cfg[wds_pkg::CFG_WIN_BIT] ? pct_of(per, wds_pkg::OPEN_END_PCT) : per; // R1 R15

      // Trigger evaluation
      if (trig && state_reg.mode == wds_pkg::WDS_STOP && state_reg.stop_off) begin
         state_next.stop_off = 1'b0; // R22
         state_next.long_win = 1'b1;
         state_next.arm1 = 1'b0;
         state_next.cfg[wds_pkg::CFG_ARM2_BIT] = 1'b0;
         restart_tmr = 1'b1;
      end else if (trig && wd_on) begin
         if (timing_chg) begin
            state_next.long_win = 1'b0; // R4
            restart_tmr = 1'b1;
         end else if (!state_reg.long_win && state_reg.cfg[wds_pkg::CFG_WIN_BIT] &&
                      state_reg.ms < pct_of(per, wds_pkg::CLOSED_PCT)) begin
            fail = 1'b1; // R16
         end else begin
            state_next.long_win = 1'b0; // R13 R15
            state_next.fail_cnt = 2'h0; // R12
            restart_tmr = 1'b1;
         end
      end else if (wd_on && state_reg.ms >= limit) begin
         fail = 1'b1; // R14 R16
      end

      // Shared tick counter
      if (restart_tmr || !wd_on) begin // R24
         state_next.pre = 20'd0;
         state_next.ms = 11'd0;
      end else if (state_reg.pre == 20'(TICK_CYC_P - 1)) begin
         state_next.pre = 20'd0;
         state_next.ms = state_reg.ms + 11'd1;
      end else begin
         state_next.pre = state_reg.pre + 20'd1;
      end

      if (fail) begin // R8
         state_next.reset_out_n = 1'b0;
         state_next.rst_cnt = 16'd0;
         if (state_reg.fail_cnt != fail_max) begin
            state_next.fail_cnt = state_reg.fail_cnt + 2'h1; // R11
         end
         // Reaching the saturation value escalates to fail-safe
         state_next.mode = (state_reg.fail_cnt + 2'h1 >= fail_max) ?
                           wds_pkg::WDS_FAILSAFE : wds_pkg::WDS_RESTART;
      end

      // Reset output hold after chip reset or watchdog reset
      if (!state_reg.reset_out_n && (state_reg.mode == wds_pkg::WDS_INIT ||
                                     state_reg.mode == wds_pkg::WDS_RESTART)) begin
         if (state_reg.rst_cnt == 16'(RST_HOLD_P - 1)) begin
            state_next.reset_out_n = 1'b1;
            state_next.long_win = 1'b1; // R3 R9
            state_next.pre = 20'd0;
            state_next.ms = 11'd0;
            if (state_reg.mode == wds_pkg::WDS_RESTART) begin
               state_next.mode = wds_pkg::WDS_NORMAL; // R9
            end
         end else begin
            state_next.rst_cnt = state_reg.rst_cnt + 16'd1;
         end
      end

      if (state_reg.mode == wds_pkg::WDS_SLEEP ||
          (state_reg.mode == wds_pkg::WDS_STOP && state_reg.stop_off)) begin
         state_next.fail_cnt = 2'h0; // R12
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         state_reg <= '{sel_s1: 1'b1, sel_s2: 1'b1, sel_prev: 1'b1, miso_oe_n: 1'b1,
                        cfg: wds_pkg::CFG_RST, mode: wds_pkg::WDS_INIT, default: '0};
      end else begin
         state_reg <= state_next;
      end
   end

   assign link.miso = state_reg.miso;
   assign link.miso_oe_n = state_reg.miso_oe_n;
   assign reset_out_n = state_reg.reset_out_n;
   assign sbc_mode = state_reg.mode;
   assign failure_count = state_reg.fail_cnt;
   assign serial_error = state_reg.ser_err;
   assign wd_running = state_reg.wd_on;
endmodule : wds_device
`default_nettype wire

// >>> rtl/wds_host.sv
// Host controller: register port in, serial frames out to the supervisor
`timescale 1ns/100ps
`default_nettype none
module wds_host #(
   parameter int HALF_P = wds_pkg::LINK_HALF_CYC
) (
   input wire logic clk,
   input wire logic rst_n,
   wds_link_if.host link,
   input wire logic [1:0] addr,
   input wire logic [15:0] wdata,
   input wire logic wr,
   input wire logic rd,
   output logic [15:0] rdata
);
   typedef enum logic [2:0] {
      H_IDLE = 3'b000,
      H_LEAD = 3'b001,
      H_SHIFT = 3'b010,
      H_TAIL = 3'b011,
      H_GAP = 3'b100
   } wds_hst_e;

   typedef struct packed {
      wds_hst_e st;
      logic [7:0] div;
      logic [4:0] cnt;
      logic [15:0] tx;
      logic [15:0] rx;
      logic [15:0] resp;
      logic [15:0] rdata;
      logic miso_s1, miso_s2;
      logic select_n, sclk, mosi;
   } wds_hst_s;

   wds_hst_s state_reg, state_next;
   logic tick;
   logic [15:0] cmd;

   always_comb begin
      state_next = state_reg;
      state_next.miso_s1 = link.miso;
      state_next.miso_s2 = state_reg.miso_s1;
      tick = state_reg.div == 8'(HALF_P - 1);
      state_next.div = tick ? 8'd0 : state_reg.div + 8'd1;
      cmd = wdata;
      // Watchdog config writes carry even parity in the top data bit
      if (wdata[wds_pkg::FRM_WR_BIT] && wdata[6:0] == wds_pkg::ADDR_WDCFG) begin
         cmd[8 + wds_pkg::CFG_PAR_BIT] = ^wdata[14:8]; // R17 R19
      end
      case (state_reg.st)
         H_IDLE: begin
            if (wr && addr == wds_pkg::HREG_CMD) begin
               state_next.st = H_LEAD;
               state_next.tx = cmd;
               state_next.mosi = cmd[15];
               state_next.select_n = 1'b0;
               state_next.cnt = 5'd0;
               state_next.div = 8'd0;
            end
         end
         H_LEAD: begin
            if (tick) begin
               state_next.st = H_SHIFT;
               state_next.sclk = 1'b1;
               state_next.rx = {state_reg.rx[14:0], state_reg.miso_s2};
               state_next.cnt = state_reg.cnt + 5'd1;
            end
         end
         H_SHIFT: begin
            if (tick) begin
               state_next.sclk = ~state_reg.sclk;
               if (state_reg.sclk) begin
                  if (state_reg.cnt == 5'(wds_pkg::FRAME_BITS)) begin
                     state_next.st = H_TAIL;
                  end else begin
                     state_next.tx = {state_reg.tx[14:0], 1'b0};
                     state_next.mosi = state_reg.tx[14];
                  end
               end else begin
                  state_next.rx = {state_reg.rx[14:0], state_reg.miso_s2};
                  state_next.cnt = state_reg.cnt + 5'd1;
               end
            end
         end
         H_TAIL: begin
            if (tick) begin
               state_next.st = H_GAP;
               state_next.select_n = 1'b1; // R5
               state_next.resp = state_reg.rx;
            end
         end
         H_GAP: begin
            if (tick) begin
               state_next.st = H_IDLE;
            end
         end
         default: state_next.st = H_IDLE;
      endcase
      if (rd) begin
         case (addr)
            wds_pkg::HREG_STAT: state_next.rdata = {15'h0000, state_reg.st != H_IDLE};
            wds_pkg::HREG_RESP: state_next.rdata = state_reg.resp;
            default: state_next.rdata = 16'h0000;
         endcase
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         state_reg <= '{st: H_IDLE, select_n: 1'b1, default: '0};
      end else begin
         state_reg <= state_next;
      end
   end

   assign link.select_n = state_reg.select_n;
   assign link.sclk = state_reg.sclk;
   assign link.mosi = state_reg.mosi;
   assign rdata = state_reg.rdata;
endmodule : wds_host
`default_nettype wire

// >>> rtl/wds_link_if.sv
// Serial link between host controller and watchdog supervisor
`timescale 1ns/100ps
`default_nettype none
interface wds_link_if;
   logic select_n;
   logic sclk;
   logic mosi;
   logic miso;
   logic miso_oe_n;
   modport dev (input select_n, input sclk, input mosi, output miso, output miso_oe_n);
   modport host (output select_n, output sclk, output mosi, input miso, input miso_oe_n);
endinterface : wds_link_if
`default_nettype wire

// >>> rtl/wds_pkg.sv
// Shared constants, types and helpers of the watchdog supervisor and its host
package wds_pkg;
   localparam int CLK_MHZ = 100;
   localparam int TICK_US = 1000;
   localparam int TICK_CYC = TICK_US * CLK_MHZ;
   localparam int RST_HOLD_US = 10;
   localparam int RST_HOLD_CYC = RST_HOLD_US * CLK_MHZ;
   localparam int LINK_HALF_CYC = 8;
   localparam int LONG_WIN_MS = 200;
   localparam int CLOSED_PCT = 60;
   localparam int OPEN_END_PCT = 140;
   localparam int FRAME_BITS = 16;

   // Frame layout: data byte in bits 15..8, write flag in bit 7, address in 6..0
   localparam int FRM_WR_BIT = 7;
   localparam logic [6:0] ADDR_MODE = 7'h01;
   localparam logic [6:0] ADDR_WAKE = 7'h04;
   localparam logic [6:0] ADDR_WDCFG = 7'h13;
   localparam logic [6:0] ADDR_STAT = 7'h20;

   // Watchdog config word fields
   localparam int CFG_PAR_BIT = 7;
   localparam int CFG_ARM2_BIT = 6;
   localparam int CFG_WIN_BIT = 5;
   localparam int CFG_RSV_BIT = 3;
   localparam int CFG_PER_LSB = 0;
   localparam logic [7:0] CFG_RST = 8'h04;
   localparam int WAKE_ARM1_BIT = 0;

   localparam logic [1:0] CMD_NORMAL = 2'h1;
   localparam logic [1:0] CMD_STOP = 2'h2;
   localparam logic [1:0] CMD_SLEEP = 2'h3;

   // Host-side register port
   localparam logic [1:0] HREG_CMD = 2'h0;
   localparam logic [1:0] HREG_STAT = 2'h1;
   localparam logic [1:0] HREG_RESP = 2'h2;

   typedef enum logic [2:0] {
      WDS_INIT = 3'b000,
      WDS_NORMAL = 3'b001,
      WDS_STOP = 3'b010,
      WDS_SLEEP = 3'b011,
      WDS_RESTART = 3'b100,
      WDS_FAILSAFE = 3'b101
   } wds_mode_e;

   function automatic logic wds_parity(input logic [7:0] d);
      return ^d;
   endfunction : wds_parity

   function automatic logic [10:0] wds_period_ms(input logic [2:0] sel);
      case (sel)
         3'h1: return 11'd10;
         3'h2: return 11'd20;
         3'h3: return 11'd50;
         3'h4: return 11'd100;
         3'h5: return 11'd200;
         3'h6: return 11'd500;
         3'h7: return 11'd1000;
         default: return 11'd10;
      endcase
   endfunction : wds_period_ms
endpackage : wds_pkg

// >>> test/testbench.sv
// Self-checking bench: host controller and watchdog supervisor face to face
`timescale 1ns/100ps
`default_nettype none
module testbench;
   localparam int TICK = 10;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic [1:0] addr = 2'h0;
   logic [15:0] wdata = 16'h0;
   logic wr = 1'b0;
   logic rd = 1'b0;
   logic [1:0] fail_cfg = 2'h0;
   logic [15:0] rdata, r;
   logic reset_out_n, serial_error, wd_running, reset_out_n_b, serial_error_b, wd_running_b;
   logic [2:0] sbc_mode, sbc_mode_b;
   logic [1:0] failure_count, failure_count_b;
   int miscompares = 0;
   int checks_done = 0;
   int c, sat;
   wds_link_if link ();
   wds_link_if link_b ();
   always #5 clk = ~clk;
   wds_host i_wds_host (.clk(clk), .rst_n(rst_n), .link(link.host), .addr(addr),
      .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata));
   wds_device #(.TICK_CYC_P(TICK), .RST_HOLD_P(20)) i_wds_device (.clk(clk), .rst_n(rst_n),
      .link(link.dev), .dev_mode(1'b0), .fail_cfg(fail_cfg), .reset_out_n(reset_out_n),
      .sbc_mode(sbc_mode), .failure_count(failure_count), .serial_error(serial_error),
      .wd_running(wd_running));
   // Second supervisor in development mode, fed by hand-made frames, one of them with broken parity
   wds_device #(.TICK_CYC_P(TICK), .RST_HOLD_P(20)) i_wds_device_b (.clk(clk), .rst_n(rst_n),
      .link(link_b.dev), .dev_mode(1'b1), .fail_cfg(2'h0), .reset_out_n(reset_out_n_b),
      .sbc_mode(sbc_mode_b), .failure_count(failure_count_b), .serial_error(serial_error_b),
      .wd_running(wd_running_b));
   wds_link_chk i_wds_link_chk (.clk(clk), .rst_n(rst_n), .select_n(link.select_n),
      .sclk(link.sclk), .mosi(link.mosi), .miso(link.miso), .miso_oe_n(link.miso_oe_n));

   function automatic int fail_sat(input int cfg);
      return (cfg == 1) ? 1 : 2;
   endfunction : fail_sat

   task automatic tally_and_finish;
      $display("checks %0d mismatches %0d", checks_done, miscompares);
      if (miscompares == 0 && checks_done > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask : tally_and_finish

   task automatic chk(input logic [15:0] seen, input logic [15:0] exp, input string what);
      checks_done++;
      if (seen !== exp) begin
         miscompares++;
         $display("FAIL %0t %s: saw %h expected %h", $time, what, seen, exp);
      end
   endtask : chk

   task automatic bus_wr(input logic [1:0] a, input logic [15:0] d);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
   endtask : bus_wr

   task automatic bus_rd(input logic [1:0] a, output logic [15:0] d);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      @(negedge clk);
      d = rdata;
      @(posedge clk);
   endtask : bus_rd

   // One frame through the host, polled until it is no longer busy
   task automatic frame(input logic [7:0] d, input logic w, input logic [6:0] a);
      int n;
      bus_wr(wds_pkg::HREG_CMD, {d, w, a});
      n = 0;
      r = 16'h1;
      while (r[0] !== 1'b0 && n < 400) begin
         bus_rd(wds_pkg::HREG_STAT, r);
         n++;
      end
      if (n >= 400) begin
         chk({15'h0, r[0]}, 16'h0, "link stuck busy");
         tally_and_finish;
      end
      repeat (6) @(posedge clk);
   endtask : frame

   task automatic wait_ro(input logic lvl, input int lim);
      int n;
      n = 0;
      while (reset_out_n !== lvl && n < lim) begin
         @(posedge clk);
         n++;
      end
      if (n >= lim) begin
         chk({15'h0, reset_out_n}, {15'h0, lvl}, "reset output wait");
         tally_and_finish;
      end
   endtask : wait_ro

   // Bench acts as host on the second link; data line inverted once released
   task automatic bb_frame(input logic [15:0] w);
      link_b.select_n <= 1'b0;
      for (int i = 15; i >= 0; i--) begin
         link_b.mosi <= w[i];
         repeat (4) @(posedge clk);
         link_b.sclk <= 1'b1;
         repeat (4) @(posedge clk);
         link_b.sclk <= 1'b0;
      end
      repeat (4) @(posedge clk);
      link_b.select_n <= 1'b1;
      repeat (8) @(posedge clk);
      link_b.mosi <= ~w[0];
   endtask : bb_frame

   initial begin
      link_b.select_n = 1'b1;
      link_b.sclk = 1'b0;
      link_b.mosi = 1'b0;
      void'($urandom(32'hD12B));
      repeat (4) @(posedge clk);
      chk(16'(sbc_mode), 16'(wds_pkg::WDS_INIT), "mode in reset");
      @(posedge clk);
      rst_n <= 1'b1;
      wait_ro(1'b1, 100);
      repeat (3) @(posedge clk);
      chk({15'h0, wd_running}, 16'h1, "long window after release");
      $display("test reset done");
      bb_frame({8'h01, 1'b1, wds_pkg::ADDR_MODE});
      bb_frame({8'h88, 1'b1, wds_pkg::ADDR_WDCFG});
      chk({15'h0, serial_error_b}, 16'h0, "good parity with bit 3");
      bb_frame({8'h08, 1'b1, wds_pkg::ADDR_WDCFG});
      chk({15'h0, serial_error_b}, 16'h1, "bad parity flagged");
      $display("test parity done");
      frame(8'h00, 1'b0, wds_pkg::ADDR_WDCFG);
      frame(8'h00, 1'b0, wds_pkg::ADDR_STAT);
      bus_rd(wds_pkg::HREG_RESP, r);
      chk({8'h0, r[15:8]}, {8'h0, wds_pkg::CFG_RST}, "default config");
      frame({6'h0, wds_pkg::CMD_NORMAL}, 1'b1, wds_pkg::ADDR_MODE);
      chk(16'(sbc_mode), 16'(wds_pkg::WDS_NORMAL), "normal entry");
      frame(8'h24, 1'b1, wds_pkg::ADDR_WDCFG);
      repeat (500) @(posedge clk);
      frame(8'h24, 1'b1, wds_pkg::ADDR_WDCFG);
      chk({14'h0, failure_count}, 16'h0, "open window trigger");
      frame(8'h24, 1'b1, wds_pkg::ADDR_WDCFG);
      wait_ro(1'b0, 100);
      repeat (2) @(posedge clk);
      chk({14'h0, failure_count}, 16'h1, "closed window count");
      chk(16'(sbc_mode), 16'(wds_pkg::WDS_RESTART), "restart entry");
      wait_ro(1'b1, 200);
      repeat (3) @(posedge clk);
      chk(16'(sbc_mode), 16'(wds_pkg::WDS_NORMAL), "back to normal");
      $display("test window done");
      frame(8'h01, 1'b1, wds_pkg::ADDR_WAKE);
      frame(8'h64, 1'b1, wds_pkg::ADDR_WDCFG);
      frame(8'h64, 1'b1, wds_pkg::ADDR_WDCFG);
      wait_ro(1'b1, 200);
      frame({6'h0, wds_pkg::CMD_STOP}, 1'b1, wds_pkg::ADDR_MODE);
      chk({15'h0, wd_running}, 16'h0, "disabled in stop");
      chk({14'h0, failure_count}, 16'h0, "count cleared when off");
      frame(8'h24, 1'b1, wds_pkg::ADDR_WDCFG);
      chk({15'h0, wd_running}, 16'h1, "stop trigger enables");
      chk(16'(sbc_mode), 16'(wds_pkg::WDS_STOP), "still stop");
      frame({6'h0, wds_pkg::CMD_NORMAL}, 1'b1, wds_pkg::ADDR_MODE);
      chk(16'(sbc_mode), 16'(wds_pkg::WDS_NORMAL), "normal from stop");
      $display("test stop done");
      c = $urandom_range(3);
      sat = fail_sat(c);
      fail_cfg <= 2'(c);
      frame(8'h04, 1'b1, wds_pkg::ADDR_WDCFG);
      repeat ($urandom_range(500)) @(posedge clk);
      frame(8'h04, 1'b1, wds_pkg::ADDR_WDCFG);
      repeat (800) @(posedge clk);
      chk({13'h0, reset_out_n, failure_count}, 16'h4, "time-out trigger accepted");
      for (int k = 1; k <= 2; k++) begin
         wait_ro(1'b0, 4000);
         repeat (2) @(posedge clk);
         chk({14'h0, failure_count}, 16'(k), "expiry count");
         if (k == sat) begin
            chk(16'(sbc_mode), 16'(wds_pkg::WDS_FAILSAFE), "fail-safe entry");
            break;
         end
         chk(16'(sbc_mode), 16'(wds_pkg::WDS_RESTART), "restart on expiry");
         wait_ro(1'b1, 200);
      end
      $display("test expiry done");
      chk({15'h0, reset_out_n_b}, 16'h1, "no reset in development");
      chk({15'h0, wd_running_b}, 16'h0, "off in development");
      $display("test development done");
      tally_and_finish;
   end
endmodule : testbench
`default_nettype wire

// >>> test/wds_link_chk.sv
// Checker of the serial link between host controller and watchdog supervisor
`timescale 1ns/100ps
`default_nettype none
module wds_link_chk (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic select_n,
   input wire logic sclk,
   input wire logic mosi,
   input wire logic miso,
   input wire logic miso_oe_n
);
   logic sclk_reg;
   logic [4:0] cnt_reg;
   logic [15:0] sh_reg;
   // Rebuild each frame so its length and parity can be judged when it closes
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         sclk_reg <= 1'b0;
         cnt_reg <= 5'h0;
         sh_reg <= 16'h0;
      end else begin
         sclk_reg <= sclk;
         if (select_n) begin
            cnt_reg <= 5'h0;
         end else if (sclk && !sclk_reg) begin
            cnt_reg <= cnt_reg + 5'h1;
            sh_reg <= {sh_reg[14:0], mosi};
         end
      end
   end
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_n);
   a_sclk_idle_low: assert property (select_n |-> !sclk)
      else $error("clock high while deselected");
   a_frame_sixteen: assert property ($rose(select_n) |-> cnt_reg == 5'h10)
      else $error("frame not sixteen bits");
   a_cfg_even_parity: assert property ($rose(select_n) &&
      sh_reg[7:0] == {1'b1, wds_pkg::ADDR_WDCFG} |-> ^sh_reg[15:8] == 1'b0)
      else $error("config write with odd parity");
   a_mosi_held_high: assert property (sclk && $past(sclk) |-> $stable(mosi))
      else $error("data moved while clock high");
   a_sclk_high_len: assert property ($rose(sclk) |-> sclk[*4])
      else $error("clock high phase short");
   a_sclk_low_len: assert property ($fell(sclk) |-> !sclk[*4])
      else $error("clock low phase short");
   a_select_gap: assert property ($rose(select_n) |-> select_n[*4])
      else $error("gap between frames short");
   a_lead_time: assert property ($fell(select_n) |-> !sclk[*4])
      else $error("clock too soon after select");
   a_miso_release: assert property ($rose(select_n) |-> ##[1:8] miso_oe_n)
      else $error("return line not released");
   a_miso_drive: assert property ($fell(select_n) |-> ##[1:8] !miso_oe_n)
      else $error("return line not driven");
   c_cfg_frame: cover property ($rose(select_n) && sh_reg[7:0] == {1'b1, wds_pkg::ADDR_WDCFG});
   c_read_frame: cover property ($rose(select_n) && !sh_reg[7]);
   c_miso_on: cover property (!miso_oe_n && miso);
endmodule : wds_link_chk
`default_nettype wire
